// ### core/tmc_map.svh
// Purpose: register offsets, reset values and timing counts of the temperature monitor
// Assumes: 8-bit register port, 250 MHz system clock
// Notes: definitions only
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH
// register offsets
`define TMC_OFS_MAIN_STAT 8'h02
`define TMC_OFS_CONFIG 8'h03
`define TMC_OFS_ONE_SHOT 8'h04
`define TMC_OFS_CHAN_EN 8'h05
`define TMC_OFS_FILTER 8'h06
`define TMC_OFS_MODEL_SEL 8'h07
`define TMC_OFS_MODEL_STAT 8'h08
`define TMC_OFS_DIODE_STAT 8'h09
`define TMC_OFS_ALERT_STAT 8'h0A
`define TMC_OFS_MASK 8'h0D
`define TMC_OFS_TEMP_S 8'h10
`define TMC_OFS_TEMP_U 8'h20
`define TMC_OFS_HYST 8'h30
`define TMC_OFS_LIMIT 8'h31
`define TMC_OFS_OFFSET 8'h38
`define TMC_OFS_MFR_ID 8'hFE
`define TMC_OFS_REV_ID 8'hFF
// field positions
`define TMC_CFG_FQ3 0
`define TMC_CFG_FQ4 1
`define TMC_CFG_RATE_LO 4
`define TMC_CFG_STANDBY 6
// reset values
`define TMC_RST_CONFIG 8'h23
`define TMC_RST_CHAN_EN 5'h1F
`define TMC_RST_FILTER 4'hF
`define TMC_RST_MODEL 5'h02
`define TMC_RST_MASK1 5'h19
`define TMC_RST_MASK2 5'h00
`define TMC_RST_MASK3 5'h07
`define TMC_RST_LIM_HI 8'h6E
`define TMC_RST_LIM 8'h55
`define TMC_RST_HYST 8'h05
// timing
`define TMC_CLK_KHZ 250000
`define TMC_TOUT_MIN_MS 25
`define TMC_FQ_DEPTH 2'h3
`define TMC_RATE0_MS 12'h000
`define TMC_RATE1_MS 12'h1F4
`define TMC_RATE2_MS 12'h3E8
`define TMC_RATE3_MS 12'h7D0
`endif

// ### core/tmc_pkg.sv
// Purpose: types of the temperature monitor
// Assumes: nothing
// Notes: numbers live in tmc_map.svh
`default_nettype none
package tmc_pkg;
   typedef enum logic [3:0] {
      TMC_IDLE = 4'h1,
      TMC_START = 4'h2,
      TMC_WAIT = 4'h4,
      TMC_GAP = 4'h8
   } tmc_state_t;
   typedef logic signed [16:0] tmc_temp_t;
endpackage
`default_nettype wire

// ### core/tmc_monitor.sv
// Purpose: digital side of a five channel temperature monitor
// Assumes: analog converter hands back one raw reading per request, in 1/256 degC
// Notes: channel 0 local, 1..4 remote; register port answers one cycle after the strobe
// Contract
// - unmasked channel over limit pulls alert low
// - alert pin levels readable in status
// - remotes 1,2 have two limits each
// - remotes 3,4 and local have one limit each, used by both alerts
// - alert 3 uses alert 2 limits, own mask
// - one hysteresis for all comparisons
// - remotes 1,2 filtered, 1/32 degC resolution
// - remotes 3,4 use fault queue
// - one-shot write in standby runs one round
// - disabled channels skipped in sequence
// - eight bit registers, MSB and LSB bytes
// - signed form all, unsigned form remotes
// - remote diode faults reported in status
// - main status: busy, not ready, summaries
// - per channel diode model select, status
// - remote offset corrects reading
// - config: standby, fault queue, rate
// - bus low too long resets serial port
// - reads anytime return last result
// - bus timeout between 25 and 35 ms
// - fault queue needs three consecutive overs
// - release below limit minus hysteresis
// - slave only, never drives clock
//
// Implementation choices: the strobed register port and the register offsets.
`include "tmc_map.svh"
`default_nettype none
module tmc_monitor
   import tmc_pkg::*;
#(
   parameter int unsigned MS_CYC = `TMC_CLK_KHZ,
   parameter int unsigned TOUT_CYC = `TMC_TOUT_MIN_MS * `TMC_CLK_KHZ,
   parameter logic [7:0] MFR_ID = 8'hA5, // arbitrary
   parameter logic [7:0] REV_ID = 8'h5A // arbitrary
)(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic conv_start_o,
   output logic [2:0] conv_chan_o,
   output logic conv_model_o,
   input wire logic adc_valid_i,
   input wire logic [16:0] adc_data_i,
   input wire logic [3:0] diode_fault_i,
   input wire logic smb_clk_i,
   input wire logic smb_dat_i,
   input wire logic smb_dat_req_i,
   output logic smb_dat_o,
   output logic smb_dat_oe_o,
   output logic smb_reset_o,
   output logic crit_alert_out_1_n_o,
   output logic crit_alert_out_2_n_o,
   output logic crit_alert_out_3_n_o
);

   function automatic logic [3:0] tmc_next(input logic [4:0] en, input logic [2:0] from);
      logic [3:0] res;
      res = 4'h0;
      for (int i = 4; i >= 0; i--)
         if (en[i] && (3'(i) >= from)) res = {1'b1, 3'(i)};
      return res;
   endfunction
   // signed view clamps at +127.875 so the register never rolls over
   function automatic logic [15:0] tmc_sview(input tmc_temp_t t);
      return (t > 17'sh07FFF) ? 16'h7FE0 : t[15:0];
   endfunction
   function automatic logic [15:0] tmc_uview(input tmc_temp_t t);
      return t[16] ? 16'h0000 : t[15:0];
   endfunction
   // registers
   logic [7:0] cfg_r;
   logic [4:0] chen_r;
   logic [3:0] filt_sel_r;
   logic [4:0] model_r;
   logic [4:0] model_used_r;
   logic [4:0] mask_r [0:2];
   logic [7:0] hyst_r;
   logic [7:0] lim_r [0:6];
   logic [7:0] off_r [0:3];
   logic [3:0] fault_r;
   tmc_temp_t temp_r [0:4];
   tmc_temp_t filt_r [1:2];
   logic [4:0] upd_r;
   logic [4:0] over_r [0:1];
   logic [1:0] fq_cnt_r [0:4][0:1];
   logic alert_r [0:2];
   logic [7:0] reg_rdata_r;
   logic not_ready_r;
   logic shot_pend_r;
   tmc_state_t state_r;
   logic [2:0] ch_r;
   logic [31:0] ms_cnt_r;
   logic [11:0] elapsed_r;
   // register write decode
   wire logic wr_cfg = reg_wr_i && (reg_addr_i == `TMC_OFS_CONFIG);
   wire logic wr_shot = reg_wr_i && (reg_addr_i == `TMC_OFS_ONE_SHOT);
   wire logic wr_chen = reg_wr_i && (reg_addr_i == `TMC_OFS_CHAN_EN);
   wire logic wr_filt = reg_wr_i && (reg_addr_i == `TMC_OFS_FILTER);
   wire logic wr_model = reg_wr_i && (reg_addr_i == `TMC_OFS_MODEL_SEL);
   wire logic wr_hyst = reg_wr_i && (reg_addr_i == `TMC_OFS_HYST);
   wire logic [7:0] addr_mask = reg_addr_i - `TMC_OFS_MASK;
   wire logic [7:0] addr_lim = reg_addr_i - `TMC_OFS_LIMIT;
   wire logic [7:0] addr_off = reg_addr_i - `TMC_OFS_OFFSET;
   wire logic [7:0] addr_ts = reg_addr_i - `TMC_OFS_TEMP_S;
   wire logic [7:0] addr_tu = reg_addr_i - `TMC_OFS_TEMP_U;
   wire logic [7:0] addr_as = reg_addr_i - `TMC_OFS_ALERT_STAT;
   wire logic standby = cfg_r[`TMC_CFG_STANDBY];
   wire logic [1:0] rate_sel = cfg_r[`TMC_CFG_RATE_LO +: 2];
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cfg_r <= `TMC_RST_CONFIG;
         chen_r <= `TMC_RST_CHAN_EN;
         filt_sel_r <= `TMC_RST_FILTER;
         model_r <= `TMC_RST_MODEL;
         hyst_r <= `TMC_RST_HYST;
         mask_r[0] <= `TMC_RST_MASK1;
         mask_r[1] <= `TMC_RST_MASK2;
         mask_r[2] <= `TMC_RST_MASK3;
         for (int i = 0; i < 7; i++)
            lim_r[i] <= (i == 1 || i == 2) ? `TMC_RST_LIM_HI : `TMC_RST_LIM;
         for (int i = 0; i < 4; i++)
            off_r[i] <= 8'h00;
      end
      else if (ce_i)
      begin
         if (wr_cfg) cfg_r <= reg_wdata_i;
         if (wr_chen) chen_r <= reg_wdata_i[4:0];
         if (wr_filt) filt_sel_r <= reg_wdata_i[3:0];
         if (wr_model) model_r <= reg_wdata_i[4:0];
         if (wr_hyst) hyst_r <= reg_wdata_i;
         if (reg_wr_i && addr_mask < 8'h03) mask_r[addr_mask[1:0]] <= reg_wdata_i[4:0];
         if (reg_wr_i && addr_lim < 8'h07) lim_r[addr_lim[2:0]] <= reg_wdata_i;
         if (reg_wr_i && addr_off < 8'h04) off_r[addr_off[1:0]] <= reg_wdata_i;
      end
   end

   // conversion sequencer
   wire logic [3:0] first_ch = tmc_next(chen_r, 3'h0);
   wire logic [3:0] next_ch = tmc_next(chen_r, ch_r + 3'h1);
   wire logic ms_tick = (ms_cnt_r == MS_CYC - 1);
   wire logic [11:0] period_ms = (rate_sel == 2'h0) ? `TMC_RATE0_MS :
                                 (rate_sel == 2'h1) ? `TMC_RATE1_MS :
                                 (rate_sel == 2'h2) ? `TMC_RATE2_MS : `TMC_RATE3_MS;
   wire logic go_cont = !standby && (elapsed_r >= period_ms);
   wire logic go_round = (state_r == TMC_IDLE) && (go_cont || shot_pend_r);
   wire logic store = (state_r == TMC_WAIT) && adc_valid_i;

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_r <= TMC_IDLE;
         ch_r <= 3'h0;
         ms_cnt_r <= 32'h0;
         elapsed_r <= 12'h000;
         shot_pend_r <= 1'b0;
         not_ready_r <= 1'b1;
      end
      else if (ce_i)
      begin
         ms_cnt_r <= ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
         if (go_round) elapsed_r <= 12'h000;
         else if (ms_tick && elapsed_r != 12'hFFF) elapsed_r <= elapsed_r + 12'h001;
         // a one-shot write landing as a round starts still gets its own round
         if (wr_shot && standby) shot_pend_r <= 1'b1;
         else if (go_round) shot_pend_r <= 1'b0;
         unique case (state_r)
            TMC_IDLE:
            begin
               if (go_round)
               begin
                  ch_r <= first_ch[2:0];
                  state_r <= first_ch[3] ? TMC_START : TMC_GAP;
               end
            end
            TMC_START: state_r <= TMC_WAIT;
            TMC_WAIT:
            begin
               if (adc_valid_i)
               begin
                  ch_r <= next_ch[2:0];
                  state_r <= next_ch[3] ? TMC_START : TMC_GAP;
               end
            end
            TMC_GAP:
            begin
               not_ready_r <= 1'b0;
               state_r <= TMC_IDLE;
            end
            default: state_r <= TMC_IDLE;
         endcase
      end
   end

   assign conv_start_o = (state_r == TMC_START);
   assign conv_chan_o = ch_r;
   assign conv_model_o = model_r[ch_r];
   // reading path: filter, resolution, offset, clamp
   wire logic [1:0] fmode = (ch_r == 3'h1) ? filt_sel_r[1:0] :
                            (ch_r == 3'h2) ? filt_sel_r[3:2] : 2'h0;
   wire logic fsel = (ch_r == 3'h2);
   wire tmc_temp_t raw = adc_data_i;
   wire logic signed [17:0] fdiff = 18'(raw) - 18'(filt_r[{1'b0, fsel} + 2'h1]);
   // enhanced mode clips spikes to 4 degC per step
   wire logic signed [17:0] fclip = (fmode != 2'h3) ? fdiff :
                                    (fdiff > 18'sh00400) ? 18'sh00400 :
                                    (fdiff < -18'sh00400) ? -18'sh00400 : fdiff;
   wire logic signed [17:0] fstep = (fmode == 2'h1) ? (fclip >>> 2) : (fclip >>> 3);
   wire tmc_temp_t fnew = 17'(18'(filt_r[{1'b0, fsel} + 2'h1]) + fstep);
   wire logic filt_on = (fmode == 2'h1) || (fmode == 2'h3);
   wire tmc_temp_t res_val = filt_on ? {fnew[16:3], 3'h0} : {raw[16:5], 5'h00};
   wire logic [7:0] off_cur = (ch_r == 3'h0) ? 8'h00 : off_r[2'(ch_r - 3'h1)];
   wire logic signed [17:0] off_sum = 18'(res_val) + 18'({{5{off_cur[7]}}, off_cur, 5'h00});
   wire tmc_temp_t clamped = (off_sum > 18'sh0FFFF) ? 17'h0FFFF & {14'h3FFF, {3{filt_on}}} :
                             (off_sum < -18'sh08000) ? 17'h18000 : 17'(off_sum);

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < 5; i++)
            temp_r[i] <= 17'h00000;
         filt_r[1] <= 17'h00000;
         filt_r[2] <= 17'h00000;
         upd_r <= 5'h00;
         fault_r <= 4'h0;
         model_used_r <= `TMC_RST_MODEL;
      end
      else if (ce_i)
      begin
         upd_r <= 5'h00;
         if (store)
         begin
            temp_r[ch_r] <= clamped;
            upd_r[ch_r] <= 1'b1;
            model_used_r[ch_r] <= model_r[ch_r];
            if (ch_r != 3'h0) fault_r[2'(ch_r - 3'h1)] <= diode_fault_i[2'(ch_r - 3'h1)];
            if (ch_r == 3'h1 || ch_r == 3'h2)
            begin
               // with the filter off it tracks raw so enabling it starts without a jump
               filt_r[{1'b0, fsel} + 2'h1] <= filt_on ? fnew : raw;
            end
         end
      end
   end

   // limit comparison with shared hysteresis and fault queue
   generate
      for (genvar c = 0; c < 5; c++)
      begin : g_chan
         for (genvar l = 0; l < 2; l++)
         begin : g_lim
            localparam int LIDX = (c == 0) ? 0 : (c > 2) ? c : (l == 0) ? c : c + 4;
            wire logic [7:0] lim = lim_r[LIDX];
            wire logic above = temp_r[c] > $signed({1'b0, lim, 8'h00});
            wire logic signed [17:0] rel = $signed({2'b00, lim, 8'h00}) -
                                           $signed({2'b00, hyst_r, 8'h00});
            wire logic below = 18'(temp_r[c]) < rel;
            wire logic fq_on = (c == 3) ? cfg_r[`TMC_CFG_FQ3] :
                               (c == 4) ? cfg_r[`TMC_CFG_FQ4] : 1'b0;
            wire logic [1:0] need = fq_on ? `TMC_FQ_DEPTH : 2'h1;
            wire logic moving = over_r[l][c] ? below : above;
            always_ff @(posedge clk_sys_i or negedge rst_n_i)
            begin
               if (!rst_n_i)
               begin
                  over_r[l][c] <= 1'b0;
                  fq_cnt_r[c][l] <= 2'h0;
               end
               else if (ce_i && upd_r[c])
               begin
                  if (!moving) fq_cnt_r[c][l] <= 2'h0;
                  else if (fq_cnt_r[c][l] + 2'h1 >= need)
                  begin
                     fq_cnt_r[c][l] <= 2'h0;
                     over_r[l][c] <= !over_r[l][c];
                  end
                  else fq_cnt_r[c][l] <= fq_cnt_r[c][l] + 2'h1;
               end
            end
         end
      end
   endgenerate
   wire logic [4:0] over_a = over_r[0];
   wire logic [4:0] over_b = over_r[1];
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         alert_r[0] <= 1'b0;
         alert_r[1] <= 1'b0;
         alert_r[2] <= 1'b0;
      end
      else if (ce_i)
      begin
         alert_r[0] <= |(over_a & ~mask_r[0]);
         alert_r[1] <= |(over_b & ~mask_r[1]);
         alert_r[2] <= |(over_b & ~mask_r[2]);
      end
   end
   assign crit_alert_out_1_n_o = !alert_r[0];
   assign crit_alert_out_2_n_o = !alert_r[1];
   assign crit_alert_out_3_n_o = !alert_r[2];

   // bus timeout watch on the serial pins
   logic [2:0] scl_sync_r;
   logic [2:0] sda_sync_r;
   logic scl_lvl_r;
   logic sda_lvl_r;
   logic [22:0] low_cnt_r;
   logic tout_r;
   logic smb_reset_r;
   wire logic any_low = !scl_lvl_r || !sda_lvl_r;
   wire logic tout_hit = any_low && (low_cnt_r == 23'(TOUT_CYC - 1));

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         scl_sync_r <= 3'h7;
         sda_sync_r <= 3'h7;
         scl_lvl_r <= 1'b1;
         sda_lvl_r <= 1'b1;
         low_cnt_r <= 23'h000000;
         tout_r <= 1'b0;
         smb_reset_r <= 1'b0;
      end
      else if (ce_i)
      begin
         scl_sync_r <= {scl_sync_r[1:0], smb_clk_i};
         sda_sync_r <= {sda_sync_r[1:0], smb_dat_i};
         if (scl_sync_r[1] == scl_sync_r[2]) scl_lvl_r <= scl_sync_r[2];
         if (sda_sync_r[1] == sda_sync_r[2]) sda_lvl_r <= sda_sync_r[2];
         smb_reset_r <= tout_hit;
         if (!any_low)
         begin
            low_cnt_r <= 23'h000000;
            tout_r <= 1'b0;
         end
         else if (!tout_r)
         begin
            low_cnt_r <= low_cnt_r + 23'h000001;
            if (tout_hit) tout_r <= 1'b1;
         end
      end
   end
   assign smb_reset_o = smb_reset_r;
   assign smb_dat_o = 1'b0;
   // data line released while timed out; no clock drive exists at all
   assign smb_dat_oe_o = smb_dat_req_i && !tout_r;

   // register read mux
   wire logic busy = (state_r != TMC_IDLE);
   wire logic [7:0] st_alert [0:2];
   assign st_alert[0] = {alert_r[0], 2'h0, over_a};
   assign st_alert[1] = {alert_r[1], 2'h0, over_b};
   assign st_alert[2] = {alert_r[2], 2'h0, over_b & ~mask_r[2]};
   wire logic [7:0] st_diode = {3'h0, fault_r, 1'b0};
   wire logic [7:0] st_main = {busy, not_ready_r, 2'h0, |st_alert[2][4:0],
                               |st_alert[1][4:0], |st_alert[0][4:0], |fault_r};
   wire logic [15:0] ts_word = tmc_sview(temp_r[addr_ts[3:1]]);
   wire logic [15:0] tu_word = tmc_uview(temp_r[addr_tu[3:1] + 3'h1]);
   wire logic [7:0] rd_mux =
      (reg_addr_i == `TMC_OFS_MAIN_STAT) ? st_main :
      (reg_addr_i == `TMC_OFS_CONFIG) ? cfg_r :
      (reg_addr_i == `TMC_OFS_CHAN_EN) ? {3'h0, chen_r} :
      (reg_addr_i == `TMC_OFS_FILTER) ? {4'h0, filt_sel_r} :
      (reg_addr_i == `TMC_OFS_MODEL_SEL) ? {3'h0, model_r} :
      (reg_addr_i == `TMC_OFS_MODEL_STAT) ? {3'h0, model_used_r} :
      (reg_addr_i == `TMC_OFS_DIODE_STAT) ? st_diode :
      (reg_addr_i == `TMC_OFS_HYST) ? hyst_r :
      (reg_addr_i == `TMC_OFS_MFR_ID) ? MFR_ID :
      (reg_addr_i == `TMC_OFS_REV_ID) ? REV_ID :
      (addr_as < 8'h03) ? st_alert[addr_as[1:0]] :
      (addr_mask < 8'h03) ? {3'h0, mask_r[addr_mask[1:0]]} :
      (addr_lim < 8'h07) ? lim_r[addr_lim[2:0]] :
      (addr_off < 8'h04) ? off_r[addr_off[1:0]] :
      (addr_ts < 8'h0A) ? (addr_ts[0] ? ts_word[7:0] : ts_word[15:8]) :
      (addr_tu < 8'h08) ? (addr_tu[0] ? tu_word[7:0] : tu_word[15:8]) : 8'h00;

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i) reg_rdata_r <= 8'h00;
      else if (ce_i && reg_rd_i) reg_rdata_r <= rd_mux;
   end
   assign reg_rdata_o = reg_rdata_r;

endmodule // tmc_monitor
`default_nettype wire

// ### testbench/tmc_monitor_chk.sv
// Purpose: port checks of the monitor
// Assumes: one clock domain
// Notes: shadows config and channel enables
`default_nettype none
module tmc_monitor_chk #(
   parameter int unsigned TOUT_CYC = 50
)(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic conv_start_o,
   input wire logic [2:0] conv_chan_o,
   input wire logic adc_valid_i,
   input wire logic smb_clk_i,
   input wire logic smb_dat_i,
   input wire logic smb_dat_req_i,
   input wire logic smb_dat_o,
   input wire logic smb_dat_oe_o,
   input wire logic smb_reset_o,
   input wire logic crit_alert_out_1_n_o,
   input wire logic crit_alert_out_2_n_o,
   input wire logic crit_alert_out_3_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cfg_r;
   logic [4:0] en_r;
   int unsigned low_r;
   // raw count; sync lag is covered by the windows
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         cfg_r <= 8'h23;
         en_r <= 5'h1F;
         low_r <= 0;
      end
      else
      begin
         if (reg_wr_i && reg_addr_i == 8'h03) cfg_r <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == 8'h05) en_r <= reg_wdata_i[4:0];
         low_r <= (smb_clk_i && smb_dat_i) ? 0 : low_r + 1;
      end
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   oe_req_a: assert property (smb_dat_oe_o |-> smb_dat_req_i && !smb_dat_o)
      else $error("oe without request");
   tout_early_a: assert property (smb_reset_o |-> low_r >= TOUT_CYC)
      else $error("reset too early");
   tout_late_a: assert property (low_r == TOUT_CYC |-> ##[0:10] smb_reset_o)
      else $error("reset missing");
   reset_release_a: assert property (smb_reset_o |=> !smb_reset_o && !smb_dat_oe_o)
      else $error("reset not a pulse");
   chan_skip_a: assert property (conv_start_o |-> en_r[conv_chan_o])
      else $error("disabled channel converted");
   start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
      else $error("start too long");
   unmapped_rd_a: assert property (reg_rd_i && reg_addr_i == 8'h50 |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   cfg_read_a: assert property (reg_rd_i && reg_addr_i == 8'h03
      |=> reg_rdata_o == $past(cfg_r)) else $error("config readback wrong");
   rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("rdata moved");
   alert_cause_a: assert property (!$stable({crit_alert_out_1_n_o, crit_alert_out_2_n_o,
      crit_alert_out_3_n_o}) |-> $past(adc_valid_i, 2) || $past(adc_valid_i, 3)
      || $past(adc_valid_i, 4)) else $error("alert moved alone");
endmodule // tmc_monitor_chk
`default_nettype wire

// ### testbench/tmc_adc_model.sv
// Purpose: converter model at the far side
// Assumes: one request at a time, short or long wait
// Notes: data toggles between results so stale data never match
`default_nettype none
module tmc_adc_model (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic conv_start_i,
   input wire logic [2:0] conv_chan_i,
   input wire logic slow_i,
   input wire logic [4:0][16:0] temp_tab_i,
   output logic adc_valid_o,
   output logic [16:0] adc_data_o,
   output logic [15:0] conv_cnt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy_r;
   logic [2:0] chan_r;
   logic [3:0] wait_r;
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         busy_r <= 1'b0;
         chan_r <= 3'h0;
         wait_r <= 4'h0;
         adc_valid_o <= 1'b0;
         adc_data_o <= 17'h00000;
         conv_cnt_o <= 16'h0000;
      end
      else
      begin
         adc_valid_o <= 1'b0;
         adc_data_o <= ~adc_data_o;
         if (conv_start_i)
         begin
            busy_r <= 1'b1;
            chan_r <= conv_chan_i;
            wait_r <= slow_i ? 4'h9 : 4'h0;
            conv_cnt_o <= conv_cnt_o + 16'h0001;
         end
         else if (busy_r && wait_r == 4'h0)
         begin
            busy_r <= 1'b0;
            adc_valid_o <= 1'b1;
            adc_data_o <= temp_tab_i[chan_r];
         end
         else if (busy_r)
            wait_r <= wait_r - 4'h1;
      end
endmodule // tmc_adc_model
`default_nettype wire

// ### testbench/tb_multi_channel_temp_monitor.sv
// Purpose: bench of the temperature monitor
// Assumes: filters off, zero offsets, short timeout
// Notes: readings on 1/8 degC steps, so no truncation
`default_nettype none
module tb_multi_channel_temp_monitor;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned TOUT = 50;
   localparam logic [7:0] RST_A [12] = '{8'h03, 8'h05, 8'h06, 8'h07, 8'h0D, 8'h0E,
      8'h0F, 8'h30, 8'h31, 8'h32, 8'h10, 8'h50};
   localparam logic [7:0] RST_E [12] = '{8'h23, 8'h1F, 8'h0F, 8'h02, 8'h19, 8'h00,
      8'h07, 8'h05, 8'h55, 8'h6E, 8'h00, 8'h00};
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b1;
   logic ce_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic conv_start_o, adc_valid_i, smb_dat_o, smb_dat_oe_o, smb_reset_o;
   logic [2:0] conv_chan_o;
   logic [16:0] adc_data_i;
   logic [3:0] diode_fault_i = 4'h0;
   logic smb_clk_i = 1'b1;
   logic smb_dat_i = 1'b1;
   logic smb_dat_req_i = 1'b1;
   logic crit_alert_out_1_n_o, crit_alert_out_2_n_o, crit_alert_out_3_n_o;
   logic [4:0][16:0] tab = '0;
   logic [4:0][16:0] raw;
   logic slow = 1'b0;
   logic [15:0] conv_cnt;
   logic [15:0] snap;
   logic [15:0] e;
   logic [3:0] f;
   logic [7:0] rst_seen = 8'h00;
   int seed = 32'h3813b43a;
   int error_cnt = 0;
   int cmp_count = 0;
   tmc_monitor #(.MS_CYC(10), .TOUT_CYC(TOUT)) tmc_monitor_inst (.clk_sys_i, .rst_n_i, .ce_i,
      .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .conv_start_o,
      .conv_chan_o, .conv_model_o(), .adc_valid_i, .adc_data_i, .diode_fault_i, .smb_clk_i,
      .smb_dat_i, .smb_dat_req_i, .smb_dat_o, .smb_dat_oe_o, .smb_reset_o,
      .crit_alert_out_1_n_o, .crit_alert_out_2_n_o, .crit_alert_out_3_n_o);
   tmc_adc_model tmc_adc_model_inst (.clk_sys_i, .rst_n_i, .conv_start_i(conv_start_o),
      .conv_chan_i(conv_chan_o), .slow_i(slow), .temp_tab_i(tab), .adc_valid_o(adc_valid_i),
      .adc_data_o(adc_data_i), .conv_cnt_o(conv_cnt));
   initial forever #2 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (smb_reset_o) rst_seen <= rst_seen + 8'h01;
   function automatic logic [15:0] exp_s(input logic [16:0] r);
      if ($signed(r) > $signed(17'h07FE0)) return 16'h7FE0;
      if ($signed(r) < $signed(17'h18000)) return 16'h8000;
      return r[15:0] & 16'hFFE0;
   endfunction
   function automatic logic [15:0] exp_u(input logic [16:0] r);
      return r[16] ? 16'h0000 : r[15:0] & 16'hFFE0;
   endfunction
   task automatic tally_and_finish();
      $display("comparisons %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk8(input string n, input logic [7:0] x, input logic [7:0] g);
      cmp_count++;
      if (g !== x)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic chk_rd(input string n, input logic [7:0] a, input logic [7:0] x,
      input logic [7:0] m = 8'hFF);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1;
      chk8(n, x, reg_rdata_o & m);
   endtask
   // waits for n round starts at channel 0, so n-1 full rounds plus 4 cycles
   task automatic rounds(input int n);
      repeat (n)
         do @(negedge clk_sys_i); while (!(conv_start_o && conv_chan_o == 3'h0));
      repeat (4) @(posedge clk_sys_i);
   endtask
   task automatic step(input int c, input int d, input logic [2:0] x);
      @(posedge clk_sys_i);
      tab[c] <= 17'(d * 256);
      rounds(2);
      @(negedge clk_sys_i);
      chk8("alert_pins", {5'h0, x}, {5'h0, crit_alert_out_1_n_o, crit_alert_out_2_n_o,
         crit_alert_out_3_n_o});
   endtask
   initial
   begin
      repeat (40000) @(posedge clk_sys_i);
      error_cnt++;
      tally_and_finish();
   end
   initial
   begin
      rst_n_i <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 12; i++)
         chk_rd("reset_value", RST_A[i], RST_E[i]);
      wr(8'h06, 8'h00);
      wr(8'h03, 8'h00);
      step(3, 25, 3'b111);
      step(3, 90, 3'b100);
      chk_rd("alert2_status", 8'h0B, 8'h08, 8'h1F);
      step(3, 82, 3'b100);
      step(3, 79, 3'b111);
      step(1, 100, 3'b101);
      step(1, 115, 3'b001);
      step(1, 25, 3'b111);
      step(0, 90, 3'b101);
      step(0, 25, 3'b111);
      wr(8'h03, 8'h01);
      step(3, 90, 3'b111);
      step(3, 90, 3'b100);
      step(3, 25, 3'b100);
      step(3, 25, 3'b111);
      wr(8'h03, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         for (int c = 0; c < 5; c++)
            raw[c] = 17'($random(seed)) & 17'h1FFE0;
         if (i == 0)
            raw[2:1] = {17'h1FF00, 17'h0FF00};
         @(posedge clk_sys_i);
         tab <= raw;
         slow <= raw[0][5];
         rounds(2);
         for (int c = 0; c < 5; c++)
         begin
            e = exp_s(raw[c]);
            chk_rd("temp_signed_msb", 8'(16 + 2 * c), e[15:8]);
            chk_rd("temp_signed_lsb", 8'(17 + 2 * c), e[7:0]);
            e = exp_u(raw[c]);
            if (c > 0)
               chk_rd("temp_unsigned", 8'(30 + 2 * c), e[15:8]);
         end
      end
      f = 4'($random(seed)) | 4'h1;
      @(posedge clk_sys_i);
      diode_fault_i <= f;
      rounds(2);
      chk_rd("diode_fault", 8'h09, {3'h0, f, 1'b0});
      wr(8'h03, 8'h40);
      repeat (100) @(posedge clk_sys_i);
      wr(8'h05, 8'h15);
      snap = conv_cnt;
      repeat (100) @(posedge clk_sys_i);
      chk8("standby_idle", snap[7:0], conv_cnt[7:0]);
      chk_rd("main_busy", 8'h02, 8'h00, 8'h80);
      wr(8'h04, 8'h00);
      repeat (200) @(posedge clk_sys_i);
      chk8("one_shot_count", 8'(snap + 16'h0003), conv_cnt[7:0]);
      smb_dat_i <= 1'b0;
      repeat (TOUT - 10) @(posedge clk_sys_i);
      smb_dat_i <= 1'b1;
      smb_clk_i <= 1'b0;
      repeat (TOUT + 12) @(posedge clk_sys_i);
      #1;
      chk8("bus_reset_count", 8'h01, rst_seen);
      chk8("data_released", 8'h00, {7'h0, smb_dat_oe_o});
      smb_clk_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      #1;
      chk8("data_enable_back", 8'h01, {7'h0, smb_dat_oe_o});
      tally_and_finish();
   end
endmodule // tb_multi_channel_temp_monitor
bind tmc_monitor tmc_monitor_chk #(.TOUT_CYC(TOUT_CYC)) tmc_monitor_chk_inst (.clk_sys_i,
   .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .conv_start_o,
   .conv_chan_o, .adc_valid_i, .smb_clk_i, .smb_dat_i, .smb_dat_req_i, .smb_dat_o,
   .smb_dat_oe_o, .smb_reset_o, .crit_alert_out_1_n_o, .crit_alert_out_2_n_o,
   .crit_alert_out_3_n_o);
`default_nettype wire
